/* hdl/fcs_pkg.sv */
// constants and types for the flash command and status host controller
// Notes on behaviour
// - host issues every command cycle as a write, except array and query reads.
// - reset command leaves identification mode or recovers after timeout flag.
// - short program only after bypass entry; bypass exit returns to read.
// - host reads status at the program address or inside an erased sector.
package fcs_pkg;

	localparam int unsigned CLK_MHZ        = 25;
	localparam int unsigned ADDR_W         = 21;
	localparam int unsigned DATA_W         = 16;
	localparam int unsigned STROBE_NS      = 80;
	localparam int unsigned STROBE_CYC     = (STROBE_NS * CLK_MHZ + 999) / 1000;

	// command cycle addresses and data
	localparam logic [ADDR_W-1:0] A_UNLOCK1 = 21'h000555;
	localparam logic [ADDR_W-1:0] A_UNLOCK2 = 21'h0002aa;
	localparam logic [ADDR_W-1:0] A_QUERY   = 21'h000055;
	localparam logic [7:0] D_UNLOCK1   = 8'haa;
	localparam logic [7:0] D_UNLOCK2   = 8'h55;
	localparam logic [7:0] D_RESET     = 8'hf0;
	localparam logic [7:0] D_ID        = 8'h90;
	localparam logic [7:0] D_PROGRAM   = 8'ha0;
	localparam logic [7:0] D_BYP_ENTER = 8'h20;
	localparam logic [7:0] D_BYP_EXIT  = 8'h00;
	localparam logic [7:0] D_ERASE_PRE = 8'h80;
	localparam logic [7:0] D_CHIP_ERS  = 8'h10;
	localparam logic [7:0] D_SECT_ERS  = 8'h30;
	localparam logic [7:0] D_SUSPEND   = 8'hb0;
	localparam logic [7:0] D_RESUME    = 8'h30;
	localparam logic [7:0] D_QUERY     = 8'h98;

	// status bit positions
	localparam int unsigned B_POLL   = 7;
	localparam int unsigned B_TOG1   = 6;
	localparam int unsigned B_TMO    = 5;
	localparam int unsigned B_EWIN   = 3;
	localparam int unsigned B_TOG2   = 2;
	localparam int unsigned SECT_LSB = 12;

	// query answers and index addresses
	localparam logic [ADDR_W-1:0] A_LOCKQ = 21'h000003;
	localparam logic [ADDR_W-1:0] A_PROTQ = 21'h000002;
	localparam logic [7:0] V_LOCKED   = 8'h99;
	localparam logic [7:0] V_UNLOCKED = 8'h19;
	localparam logic [7:0] V_PROT     = 8'h01;
	localparam logic [7:0] V_UNPROT   = 8'h00;

	typedef enum logic [3:0]
	{
		OP_READ    = 4'h0,
		OP_RESET   = 4'h1,
		OP_PROGRAM = 4'h2,
		OP_BYP_ON  = 4'h3,
		OP_BYP_PGM = 4'h4,
		OP_BYP_OFF = 4'h5,
		OP_CHIP_ER = 4'h6,
		OP_SECT_ER = 4'h7,
		OP_SUSPEND = 4'h8,
		OP_RESUME  = 4'h9,
		OP_QUERY   = 4'ha,
		OP_LOCKQ   = 4'hb,
		OP_PROTQ   = 4'hc,
		OP_POLL    = 4'hd
	} fcs_op_t;

	typedef struct packed
	{
		fcs_op_t             op;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   data;
	} fcs_req_t;

	typedef struct packed
	{
		logic                we;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   data;
	} fcs_cyc_t;

	typedef struct packed
	{
		logic                busy;
		logic                done;
		logic                fail;
		logic                locked;
		logic                prot;
		logic                suspended;
	} fcs_stat_t;

	localparam logic [3:0] N_ZERO = 4'h0;

endpackage

/* hdl/fcs_bus_cycle.sv */
// one asynchronous flash bus cycle: write or read with strobe timing
`timescale 1ns/1ns
module fcs_bus_cycle
	import fcs_pkg::*;
#(
	parameter int unsigned PULSE = STROBE_CYC
)
(
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// request side
	input  wire logic              start,
	input  wire fcs_cyc_t          cyc,
	output logic                   done,
	output logic [DATA_W-1:0]      rdata,
	// flash pins
	output logic                   ce_n,
	output logic                   we_n,
	output logic                   oe_n,
	output logic [ADDR_W-1:0]      addr,
	output logic [DATA_W-1:0]      dq_out,
	output logic                   dq_oe_n,
	input  wire logic [DATA_W-1:0] dq_in
);

	typedef enum logic [3:0]
	{
		S_IDLE = 4'b0001,
		S_SET  = 4'b0010,
		S_HOLD = 4'b0100,
		S_END  = 4'b1000
	} fcs_bst_t;

	fcs_bst_t    st_q;
	logic [7:0]  cnt_q;
	logic        last;

	assign last = (cnt_q == 8'(PULSE));

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q    <= S_IDLE;
			cnt_q   <= 8'h00;
			ce_n    <= 1'b1;
			we_n    <= 1'b1;
			oe_n    <= 1'b1;
			addr    <= '0;
			dq_out  <= '0;
			dq_oe_n <= 1'b1;
			done    <= 1'b0;
			rdata   <= '0;
		end
		else
		begin
			done <= 1'b0;
			case (st_q)
				S_IDLE:
				begin
					if (start)
					begin
						// address and data set up before strobes fall
						addr    <= cyc.addr;
						dq_out  <= cyc.data;
						dq_oe_n <= !cyc.we;
						st_q    <= S_SET;
					end
				end
				S_SET:
				begin
					ce_n  <= 1'b0;
					we_n  <= !cyc.we;
					oe_n  <= cyc.we;
					cnt_q <= 8'h00;
					st_q  <= S_HOLD;
				end
				S_HOLD:
				begin
					cnt_q <= cnt_q + 8'h01;
					if (last)
					begin
						// strobes rise together while data is still held
						rdata <= dq_in;
						ce_n  <= 1'b1;
						we_n  <= 1'b1;
						oe_n  <= 1'b1;
						st_q  <= S_END;
					end
				end
				S_END:
				begin
					dq_oe_n <= 1'b1;
					done    <= 1'b1;
					st_q    <= S_IDLE;
				end
				default:
					st_q <= S_IDLE;
			endcase
		end
	end

endmodule

/* hdl/fcs_host.sv */
// host controller that issues flash command sequences and tracks status
`timescale 1ns/1ns
module fcs_host
	import fcs_pkg::*;
#(
	parameter int unsigned POLL_MAX = 200000
)
(
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// user request
	input  wire logic              req_valid,
	input  wire fcs_req_t          req,
	output logic                   req_ready,
	// user answer
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_data,
	output fcs_stat_t              rsp_stat,
	// flash pins
	output logic                   ce_n,
	output logic                   we_n,
	output logic                   oe_n,
	output logic [ADDR_W-1:0]      addr,
	output logic [DATA_W-1:0]      dq_out,
	output logic                   dq_oe_n,
	input  wire logic [DATA_W-1:0] dq_in,
	input  wire logic              ready_busy_n
);

	// ****************************************************************
	// sequence state
	// ****************************************************************
	typedef enum logic [5:0]
	{
		H_IDLE = 6'b000001,
		H_CYC  = 6'b000010,
		H_WAIT = 6'b000100,
		H_POLL = 6'b001000,
		H_PWT  = 6'b010000,
		H_RSP  = 6'b100000
	} fcs_hst_t;

	fcs_hst_t          st_q;
	fcs_req_t          cur_q;
	logic [2:0]        idx_q;
	logic [2:0]        ncyc;
	logic              bypass_q;
	logic              erasing_q;
	logic              susp_q;
	logic              idmode_q;
	logic [DATA_W-1:0] prev_q;
	logic              first_q;
	logic [31:0]       pcnt_q;
	logic              cstart_q;
	fcs_cyc_t          cyc;
	logic              cdone;
	logic [DATA_W-1:0] crd;
	logic              tog1;
	logic              tog2;
	logic              tmo;
	logic              allowed;
	logic              is_poll;

	// cycle count of each command sequence
	function automatic logic [2:0] seq_len(input fcs_op_t op);
		case (op)
			OP_PROGRAM: seq_len = 3'd4;
			OP_BYP_ON:  seq_len = 3'd3;
			OP_BYP_PGM: seq_len = 3'd2;
			OP_BYP_OFF: seq_len = 3'd2;
			OP_CHIP_ER: seq_len = 3'd6;
			OP_SECT_ER: seq_len = 3'd6;
			OP_LOCKQ:   seq_len = 3'd4;
			OP_PROTQ:   seq_len = 3'd4;
			default:    seq_len = 3'd1;
		endcase
	endfunction

	// one bus cycle of a sequence; upper data byte kept zero except in program data cycles, address fixed except in target address cycles
	function automatic fcs_cyc_t cyc_of(input fcs_req_t r, input logic [2:0] i);
		fcs_cyc_t c;
		c.we   = 1'b1;
		c.addr = A_UNLOCK1;
		c.data = {8'h00, D_UNLOCK1};
		if (r.op == OP_READ || r.op == OP_POLL)
		begin
			// plain read, no unlock cycles in front of it
			c.we   = 1'b0;
			c.addr = r.addr;
		end
		else if (r.op == OP_RESET || r.op == OP_SUSPEND || r.op == OP_RESUME)
		begin
			c.addr = r.addr;
			c.data = {8'h00, (r.op == OP_RESET) ? D_RESET :
				(r.op == OP_SUSPEND) ? D_SUSPEND : D_RESUME};
		end
		else if (r.op == OP_QUERY)
		begin
			c.addr = A_QUERY;
			c.data = {8'h00, D_QUERY};
		end
		else if (r.op == OP_BYP_PGM || r.op == OP_BYP_OFF)
		begin
			c.addr = (i == 3'd1 && r.op == OP_BYP_PGM) ? r.addr : '0;
			c.data = (i == 3'd1) ? ((r.op == OP_BYP_PGM) ? r.data : '0) :
				{8'h00, (r.op == OP_BYP_PGM) ? D_PROGRAM : D_ID};
		end
		else if (i == 3'd1 || i == 3'd4)
		begin
			c.addr = A_UNLOCK2;
			c.data = {8'h00, D_UNLOCK2};
		end
		else if (i == 3'd2)
		begin
			c.data = {8'h00, (r.op == OP_PROGRAM) ? D_PROGRAM :
				(r.op == OP_BYP_ON) ? D_BYP_ENTER :
				(r.op == OP_CHIP_ER || r.op == OP_SECT_ER) ? D_ERASE_PRE : D_ID};
		end
		else if (i == 3'd3)
		begin
			// fourth query cycle is a read; only the protect query picks the sector by address bits
			c.we   = !(r.op == OP_LOCKQ || r.op == OP_PROTQ);
			c.addr = (r.op == OP_PROTQ) ?
				{r.addr[ADDR_W-1:SECT_LSB], A_PROTQ[SECT_LSB-1:0]} :
				(r.op == OP_LOCKQ) ? A_LOCKQ : (r.op == OP_PROGRAM) ? r.addr : A_UNLOCK1;
			c.data = (r.op == OP_PROGRAM) ? r.data : {8'h00, D_UNLOCK1};
		end
		else if (i == 3'd5)
		begin
			c.addr = (r.op == OP_SECT_ER) ? {r.addr[ADDR_W-1:SECT_LSB], 12'h000} : A_UNLOCK1;
			c.data = {8'h00, (r.op == OP_SECT_ER) ? D_SECT_ERS : D_CHIP_ERS};
		end
		return c;
	endfunction

	assign ncyc    = seq_len(cur_q.op);
	assign cyc     = is_poll ? fcs_cyc_t'{we: 1'b0, addr: cur_q.addr, data: '0} :
		cyc_of(cur_q, idx_q);
	assign is_poll = (st_q == H_POLL) || (st_q == H_PWT);
	assign tog1    = crd[B_TOG1] != prev_q[B_TOG1];
	assign tog2    = crd[B_TOG2] != prev_q[B_TOG2];
	assign tmo     = crd[B_TMO];

	// commands gated by tracked device mode
	assign allowed = (req.op == OP_BYP_PGM) ? bypass_q :
		(req.op == OP_SUSPEND) ? (erasing_q && !susp_q) :
		(req.op == OP_RESUME) ? susp_q :
		(req.op == OP_QUERY) ? (idmode_q || (ready_busy_n && !bypass_q)) : 1'b1;

	// ****************************************************************
	// bus cycle engine
	// ****************************************************************
	fcs_bus_cycle u_cyc
	(
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.start   (cstart_q),
		.cyc     (cyc),
		.done    (cdone),
		.rdata   (crd),
		.ce_n    (ce_n),
		.we_n    (we_n),
		.oe_n    (oe_n),
		.addr    (addr),
		.dq_out  (dq_out),
		.dq_oe_n (dq_oe_n),
		.dq_in   (dq_in)
	);

	// ****************************************************************
	// sequencer
	// ****************************************************************
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q      <= H_IDLE;
			cur_q     <= '0;
			idx_q     <= 3'd0;
			bypass_q  <= 1'b0;
			erasing_q <= 1'b0;
			susp_q    <= 1'b0;
			idmode_q  <= 1'b0;
			prev_q    <= '0;
			first_q   <= 1'b0;
			pcnt_q    <= '0;
			cstart_q  <= 1'b0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data  <= '0;
			rsp_stat  <= '0;
		end
		else
		begin
			cstart_q  <= 1'b0;
			rsp_valid <= 1'b0;
			req_ready <= (st_q == H_IDLE) && !req_valid;
			case (st_q)
				H_IDLE:
				begin
					if (req_valid && req_ready)
					begin
						req_ready <= 1'b0;
						cur_q     <= req;
						idx_q     <= 3'd0;
						if (allowed)
						begin
							cstart_q <= 1'b1;
							st_q     <= H_CYC;
						end
						else
						begin
							rsp_stat.fail <= 1'b1;
							st_q          <= H_RSP;
						end
					end
				end
				H_CYC:
					st_q <= H_WAIT;
				H_WAIT:
				begin
					if (cdone)
					begin
						if (idx_q + 3'd1 < ncyc)
						begin
							idx_q    <= idx_q + 3'd1;
							cstart_q <= 1'b1;
							st_q     <= H_CYC;
						end
						else
						begin
							rsp_data <= crd;
							rsp_stat <= '0;
							case (cur_q.op)
								OP_RESET:
								begin
									// reset command leaves id mode or a timeout
									idmode_q <= 1'b0;
								end
								OP_BYP_ON:  bypass_q <= 1'b1;
								OP_BYP_OFF: bypass_q <= 1'b0;
								OP_LOCKQ:   rsp_stat.locked <= (crd[7:0] == V_LOCKED);
								OP_PROTQ:   rsp_stat.prot <= (crd[7:0] == V_PROT);
								OP_SUSPEND: susp_q <= 1'b1;
								OP_RESUME:  susp_q <= 1'b0;
								default:    ;
							endcase
							if (cur_q.op == OP_LOCKQ || cur_q.op == OP_PROTQ)
								idmode_q <= 1'b1;
							if (cur_q.op == OP_CHIP_ER || cur_q.op == OP_SECT_ER)
								erasing_q <= 1'b1;
							// program and erase go on to status polling
							if (cur_q.op == OP_PROGRAM || cur_q.op == OP_BYP_PGM ||
								cur_q.op == OP_CHIP_ER || cur_q.op == OP_SECT_ER ||
								cur_q.op == OP_POLL || cur_q.op == OP_SUSPEND)
							begin
								first_q  <= 1'b1;
								pcnt_q   <= '0;
								cstart_q <= 1'b1;
								st_q     <= H_POLL;
							end
							else
								st_q <= H_RSP;
						end
					end
				end
				H_POLL:
					st_q <= H_PWT;
				H_PWT:
				begin
					if (cdone)
					begin
						// poll at the program address or inside the erased sector
						prev_q  <= crd;
						first_q <= 1'b0;
						pcnt_q  <= pcnt_q + 32'd1;
						if (!first_q && !tog1)
						begin
							// toggle stopped: done or suspended
							// one more read gives fully valid data
							rsp_stat.done      <= 1'b1;
							rsp_stat.suspended <= susp_q && crd[B_POLL];
							rsp_stat.fail      <= 1'b0;
							rsp_stat.busy      <= !ready_busy_n;
							if (!susp_q)
								erasing_q <= 1'b0;
							st_q <= H_RSP;
						end
						else if ((!first_q && tmo && prev_q[B_TMO]) || pcnt_q == POLL_MAX)
						begin
							// timeout flag on two toggling reads: failed
							// a single high bit may be array data just after completion
							rsp_stat.fail <= 1'b1;
							rsp_stat.done <= 1'b0;
							erasing_q     <= susp_q;
							st_q          <= H_RSP;
						end
						else
						begin
							// still toggling: busy is reported and another status read starts
							rsp_stat.busy <= 1'b1;
							cstart_q      <= 1'b1;
							st_q          <= H_POLL;
						end
						rsp_data <= crd;
					end
				end
				H_RSP:
				begin
					// protected-target busy windows end like normal completion
					rsp_valid <= 1'b1;
					st_q      <= H_IDLE;
				end
				default:
					st_q <= H_IDLE;
			endcase
		end
	end

endmodule

/* bench/fcs_host_props.sv */
// checker on the pins and handshake of the flash host controller
`timescale 1ns/1ns
module fcs_host_props
	import fcs_pkg::*;
#(
	parameter int unsigned POLL_MAX = 200000
)
(
	// clock and reset
	input wire logic              ref_clk,
	input wire logic              arst_n,
	// user side
	input wire logic              req_valid,
	input wire fcs_req_t          req,
	input wire logic              req_ready,
	input wire logic              rsp_valid,
	input wire logic [DATA_W-1:0] rsp_data,
	input wire fcs_stat_t         rsp_stat,
	// flash pins
	input wire logic              ce_n,
	input wire logic              we_n,
	input wire logic              oe_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] dq_out,
	input wire logic              dq_oe_n,
	input wire logic [DATA_W-1:0] dq_in,
	input wire logic              ready_busy_n
);
	// ****
	// assertions
	// ****
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	strobe_excl_a: assert property (!(!we_n && !oe_n))
		else $error("write and read strobes low together");
	wr_drive_a: assert property (!we_n |-> !dq_oe_n)
		else $error("write strobe without driven data");
	rd_float_a: assert property (!oe_n |-> dq_oe_n)
		else $error("data driven during a read");
	addr_hold_a: assert property ((!ce_n && $past(!ce_n)) |-> $stable(addr))
		else $error("address moved inside a cycle");
	data_hold_a: assert property ((!we_n && $past(!we_n)) |-> $stable(dq_out))
		else $error("write data moved under the strobe");
	wr_width_a: assert property ($fell(we_n) |-> (!we_n && !ce_n)[*3] ##1 (we_n && ce_n))
		else $error("write strobe width wrong");
	data_after_a: assert property ($rose(we_n) |-> !dq_oe_n ##1 dq_oe_n)
		else $error("data released before strobe rise");
	rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
		else $error("answer longer than one cycle");
	take_once_a: assert property (req_valid && req_ready |=> !req_ready)
		else $error("ready stayed high after a take");

	cover property ($fell(we_n));
	cover property ($fell(oe_n));
	cover property (rsp_valid && rsp_stat.fail);
endmodule

bind fcs_host fcs_host_props #(.POLL_MAX(POLL_MAX)) i_fcs_host_props (.ref_clk(ref_clk),
	.arst_n(arst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
	.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_stat(rsp_stat), .ce_n(ce_n),
	.we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
	.dq_in(dq_in), .ready_busy_n(ready_busy_n));

/* bench/fcs_flash_model.sv */
// behavioural flash device answering the host controller
`timescale 1ns/1ns
module fcs_flash_model
	import fcs_pkg::*;
#(
	parameter int         T_PGM     = 2000,
	parameter int         T_PROT    = 1000,
	parameter int         T_ERS     = 4000,
	parameter logic [8:0] PROT_SECT = 9'h005,
	parameter logic       LOCKED    = 1'b1
)
(
	// strobes and address
	input  wire logic              ce_n,
	input  wire logic              we_n,
	input  wire logic              oe_n,
	input  wire logic [ADDR_W-1:0] addr,
	// data bus
	input  wire logic [DATA_W-1:0] dq_bus,
	output logic [DATA_W-1:0]      fl_dq,
	output logic                   fl_oe_n,
	// open drain ready/busy
	output logic                   rb_oe_n
);
	// ****
	// command decode and status
	// ****
	logic [DATA_W-1:0] mem[int];
	logic [ADDR_W-1:0] la;
	logic [DATA_W-1:0] wd, pd;
	logic [DATA_W-1:0] rd = '0;
	logic [8:0]        esect = '1;
	logic wr_act = 0, idm = 0, byp = 0, byx = 0, pgm_nxt = 0;
	logic ers = 0, susp = 0, pgm = 0, tog1 = 0, tog2 = 0;
	int   cyc = 0;
	time  busy_end = 0, left = 0;

	function automatic logic is_busy();
		return ($time < busy_end) && !susp;
	endfunction

	always #10 rb_oe_n = !is_busy();
	assign fl_oe_n = oe_n | ce_n;
	// released bus shows the inverse of the last word
	assign fl_dq = fl_oe_n ? ~rd : rd;

	always @(negedge we_n or negedge ce_n)
	begin
		if (!we_n && !ce_n)
		begin
			la = addr;
			wr_act = 1'b1;
		end
	end

	always @(posedge we_n or posedge ce_n)
	begin
		if (wr_act)
		begin
			wr_act = 1'b0;
			wd = dq_bus;
			decode();
		end
	end

	task automatic decode();
		logic [10:0] lo;
		logic [7:0]  c;
		lo = la[10:0];
		c = wd[7:0];
		if (pgm_nxt)
		begin
			pgm_nxt = 1'b0;
			pgm = 1'b1;
			pd = wd;
			busy_end = $time + ((la[20:12] == PROT_SECT) ? T_PROT : T_PGM);
			if (la[20:12] != PROT_SECT)
				mem[la] = wd;
		end
		else if (c == D_RESET)
		begin
			idm = 1'b0;
			cyc = 0;
		end
		else if (byp)
		begin
			pgm_nxt = (c == D_PROGRAM);
			byp = !(byx && c == D_BYP_EXIT);
			byx = (c == D_ID);
		end
		else if (c == D_SUSPEND && ers && is_busy())
		begin
			left = busy_end - $time;
			susp = 1'b1;
		end
		else if (c == D_RESUME && susp && cyc != 5)
		begin
			susp = 1'b0;
			busy_end = $time + left;
		end
		else if (lo == A_QUERY[10:0] && c == D_QUERY && !is_busy())
			idm = 1'b1;
		else if (lo == A_UNLOCK1[10:0] && c == D_UNLOCK1 && (cyc == 0 || cyc == 3))
			cyc++;
		else if (lo == A_UNLOCK2[10:0] && c == D_UNLOCK2 && (cyc == 1 || cyc == 4))
			cyc++;
		else if (cyc == 2)
		begin
			idm |= (c == D_ID);
			pgm_nxt = (c == D_PROGRAM);
			byp = (c == D_BYP_ENTER);
			cyc = (c == D_ERASE_PRE) ? 3 : 0;
		end
		else if (cyc == 5 && c == D_SECT_ERS)
		begin
			ers = 1'b1;
			pgm = 1'b0;
			esect = la[20:12];
			busy_end = $time + ((la[20:12] == PROT_SECT) ? T_PROT : T_ERS);
			foreach (mem[k])
				if (k[20:12] == esect && esect != PROT_SECT)
					mem[k] = '1;
			cyc = 0;
		end
		else
			cyc = 0;
	endtask

	always @(negedge oe_n or negedge ce_n)
	begin
		if (!oe_n && !ce_n)
		begin
			if (is_busy() || (susp && addr[20:12] == esect))
			begin
				tog1 ^= is_busy();
				tog2 ^= ers && addr[20:12] == esect;
				rd = {8'h00, susp | (pgm & ~pd[7]), tog1, 2'b00, ers, tog2, 2'b00};
			end
			else if (idm)
				rd = (addr[7:0] == A_LOCKQ[7:0]) ? {8'h00, LOCKED ? V_LOCKED : V_UNLOCKED} :
					{8'h00, (addr[20:12] == PROT_SECT) ? V_PROT : V_UNPROT};
			else
				rd = mem.exists(addr) ? mem[addr] : 16'hffff;
		end
	end
endmodule

/* bench/test_fcs_host.sv */
// self-checking bench for the flash host controller
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin $display("FAIL %s exp %h got %h", nm, ex, got); fail_count++; end end
module test_fcs_host
	import fcs_pkg::*;
;
	// ****
	// harness
	// ****
	logic              ref_clk = 1'b0;
	logic              arst_n = 1'b0;
	logic              req_valid = 1'b0;
	fcs_req_t          req = '0;
	logic              req_ready, rsp_valid, ce_n, we_n, oe_n, dq_oe_n, fl_oe_n, rb_oe_n;
	logic [DATA_W-1:0] rsp_data, dq_out, fl_dq;
	logic [ADDR_W-1:0] addr;
	fcs_stat_t         rsp_stat;
	int                fail_count = 0;
	int                num_checks = 0;
	int                wr_cnt = 0;
	wire [DATA_W-1:0]  dq_in = dq_oe_n ? fl_dq : dq_out;
	wire               ready_busy_n = (rb_oe_n === 1'b0) ? 1'b0 : 1'b1;

	fcs_host #(.POLL_MAX(50)) i_fcs_host (.ref_clk(ref_clk), .arst_n(arst_n),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_stat(rsp_stat), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
		.addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in),
		.ready_busy_n(ready_busy_n));
	fcs_flash_model i_fcs_flash_model (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
		.dq_bus(dq_in), .fl_dq(fl_dq), .fl_oe_n(fl_oe_n), .rb_oe_n(rb_oe_n));

	initial forever #20 ref_clk = ~ref_clk;
	always @(negedge we_n) wr_cnt++;

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic do_req(input fcs_op_t op, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		// ready only rises while valid is low, so wait for it before asking
		while (req_ready !== 1'b1 && n < 50)
		begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 50)
			fail_count++;
		req = {op, a, d};
		req_valid = 1'b1;
		@(negedge ref_clk);
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 20000)
		begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 20000)
			fail_count++;
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_program();
		do_req(OP_READ, 21'h000100, 16'h0000);
		`CHK("blank", 16'hffff, rsp_data)
		do_req(OP_PROGRAM, 21'h001234, 16'h5a3c);
		`CHK("pgm_fail", 1'b0, rsp_stat.fail)
		`CHK("pgm_done", 1'b1, rsp_stat.done)
		`CHK("pgm_ready", 1'b0, rsp_stat.busy)
		do_req(OP_READ, 21'h001234, 16'h0000);
		`CHK("pgm_data", 16'h5a3c, rsp_data)
	endtask

	task automatic t_bypass();
		int w0;
		w0 = wr_cnt;
		do_req(OP_BYP_PGM, 21'h002000, 16'h1357);
		`CHK("byp_refused", 1'b1, rsp_stat.fail)
		`CHK("byp_nowrite", w0, wr_cnt)
		do_req(OP_BYP_ON, 21'h000000, 16'h0000);
		do_req(OP_BYP_PGM, 21'h002000, 16'h1357);
		do_req(OP_BYP_OFF, 21'h000000, 16'h0000);
		do_req(OP_READ, 21'h002000, 16'h0000);
		`CHK("byp_data", 16'h1357, rsp_data)
	endtask

	task automatic t_refuse();
		fcs_op_t ops[2] = '{OP_SUSPEND, OP_RESUME};
		int      w0;
		foreach (ops[i])
		begin
			w0 = wr_cnt;
			do_req(ops[i], 21'h001000, 16'h0000);
			`CHK("susp_refused", 1'b1, rsp_stat.fail)
			`CHK("susp_nowrite", w0, wr_cnt)
		end
		do_req(OP_QUERY, 21'h000000, 16'h0000);
		`CHK("query_ok", 1'b0, rsp_stat.fail)
		do_req(OP_RESET, 21'h000000, 16'h0000);
		do_req(OP_READ, 21'h001234, 16'h0000);
		`CHK("reset_read", 16'h5a3c, rsp_data)
	endtask

	task automatic t_query();
		do_req(OP_LOCKQ, 21'h000000, 16'h0000);
		`CHK("lock_q", V_LOCKED, rsp_data[7:0])
		`CHK("lock_flag", 1'b1, rsp_stat.locked)
		do_req(OP_PROTQ, 21'h005000, 16'h0000);
		`CHK("prot_q", V_PROT, rsp_data[7:0])
		`CHK("prot_flag", 1'b1, rsp_stat.prot)
		do_req(OP_PROTQ, 21'h001000, 16'h0000);
		`CHK("unprot_q", V_UNPROT, rsp_data[7:0])
		`CHK("unprot_flag", 1'b0, rsp_stat.prot)
		do_req(OP_RESET, 21'h000000, 16'h0000);
	endtask

	task automatic t_erase();
		do_req(OP_PROGRAM, 21'h005010, 16'h0000);
		`CHK("prot_done", 1'b1, rsp_stat.done)
		do_req(OP_READ, 21'h005010, 16'h0000);
		`CHK("prot_pgm", 16'hffff, rsp_data)
		do_req(OP_SECT_ER, 21'h001000, 16'h0000);
		`CHK("ers_fail", 1'b0, rsp_stat.fail)
		`CHK("ers_done", 1'b1, rsp_stat.done)
		do_req(OP_READ, 21'h001234, 16'h0000);
		`CHK("ers_data", 16'hffff, rsp_data)
		do_req(OP_READ, 21'h002000, 16'h0000);
		`CHK("ers_other", 16'h1357, rsp_data)
	endtask

	initial
	begin
		repeat (3) @(negedge ref_clk);
		arst_n = 1'b1;
		t_program();
		t_bypass();
		t_refuse();
		t_query();
		t_erase();
		print_verdict();
	end

	initial
	begin
		#2000000;
		fail_count++;
		print_verdict();
	end
endmodule
